// *** cci_card_command_issue.v ***
// Command issue path of a memory card host: send, response, busy wait.
`timescale 1ns/100ps
`include "cci_consts.vh"

module cci_card_command_issue #(
    parameter CLK_HALF = `CCI_CARD_HALF_CYC
) (
    input wire SYS_CLK_IN,
    input wire RST_N_IN,
    input wire [31:0] ARG_IN,
    input wire ARG_WR_IN,
    input wire CMD_WR_IN,
    input wire [5:0] CMD_INDEX_IN,
    input wire [1:0] RSP_KIND_IN,
    input wire [2:0] SPECIAL_SEQ_IN,
    input wire OPEN_DRAIN_IN,
    input wire LATENCY_IN,
    input wire [1:0] XFER_CMD_IN,
    input wire XFER_DIR_IN,
    input wire [2:0] XFER_KIND_IN,
    input wire [1:0] IO_SPECIAL_SEQ_IN,
    input wire STATUS_RD_IN,
    input wire [`CCI_ST_WIDTH-1:0] INT_EN_IN,
    input wire CMD_IN,
    input wire DAT0_IN,
    output wire CARD_CLK_OUT,
    output wire CMD_OUT,
    output wire CMD_OE_OUT,
    output wire [31:0] ARG_OUT,
    output wire [135:0] RESP_OUT,
    output wire [1:0] XFER_CMD_OUT,
    output wire XFER_DIR_OUT,
    output wire [2:0] XFER_KIND_OUT,
    output wire [`CCI_ST_WIDTH-1:0] STATUS_OUT,
    output wire IRQ_OUT
);

    // ----------------------------------------------------------------
    // States
    // ----------------------------------------------------------------
    localparam S_IDLE = 5'h01;
    localparam S_SEND = 5'h02;
    localparam S_WAIT = 5'h04;
    localparam S_RECV = 5'h08;
    localparam S_BUSY = 5'h10;

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function [6:0] crc7_step;
        input [6:0] crc;
        input bit_in;
        reg fb;
        begin
            fb = bit_in ^ crc[6];
            crc7_step = {crc[5:0], 1'b0} ^ (fb ? `CCI_CRC7_POLY : 7'h00);
        end
    endfunction

    function [6:0] crc7_head;
        input [39:0] head;
        integer i;
        reg [6:0] c;
        begin
            c = `CCI_CRC7_INIT;
            for (i = 39; i >= 0; i = i - 1) begin
                c = crc7_step(c, head[i]);
            end
            crc7_head = c;
        end
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    reg cmd_meta;
    reg cmd_s;
    reg dat0_meta;
    reg dat0_s;

    always @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            cmd_meta <= `CCI_IDLE_LEVEL;
            cmd_s <= `CCI_IDLE_LEVEL;
            dat0_meta <= `CCI_IDLE_LEVEL;
            dat0_s <= `CCI_IDLE_LEVEL;
        end else begin
            cmd_meta <= CMD_IN;
            cmd_s <= cmd_meta;
            dat0_meta <= DAT0_IN;
            dat0_s <= dat0_meta;
        end
    end

    // ----------------------------------------------------------------
    // Card clock divider
    // ----------------------------------------------------------------
    reg [7:0] div_cnt;
    reg card_clk;
    wire div_wrap = (div_cnt == CLK_HALF[7:0] - 8'h01);
    wire rise_tick = div_wrap & ~card_clk;
    wire fall_tick = div_wrap & card_clk;

    always @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            div_cnt <= 8'h00;
            card_clk <= 1'b0;
        end else if (div_wrap) begin
            div_cnt <= 8'h00;
            card_clk <= ~card_clk;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // Argument register
    // ----------------------------------------------------------------
    reg [31:0] arg_reg;

    always @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            arg_reg <= 32'h0000_0000;
        end else if (ARG_WR_IN) begin
            arg_reg <= ARG_IN;
        end
    end

    // ----------------------------------------------------------------
    // Command sequencer
    // ----------------------------------------------------------------
    reg [4:0] state;
    reg [47:0] tx_shift;
    reg [7:0] tx_cnt;
    reg cmd_bit;
    reg cmd_drive;
    reg od_mode;
    reg [1:0] rsp_kind;
    reg [5:0] cmd_index;
    reg lat_sel;
    reg [6:0] wait_cnt;
    reg [135:0] rx_shift;
    reg [7:0] rx_cnt;
    reg [6:0] rx_crc;
    reg [1:0] xfer_cmd;
    reg xfer_dir;
    reg [2:0] xfer_kind;
    reg ev_released;
    reg ev_timeout;
    reg ev_crc;
    reg ev_end;
    reg ev_idx;
    reg ev_refused;

    wire [39:0] head = {`CCI_CMD_PREFIX, CMD_INDEX_IN, arg_reg};
    wire ordinary = (SPECIAL_SEQ_IN == 3'h0) &&
                    (IO_SPECIAL_SEQ_IN == 2'h0);
    wire card_busy = ~dat0_s;
    wire accept = CMD_WR_IN & state[0] & ordinary & ~card_busy;
    wire long_rsp = (rsp_kind == `CCI_RSP_LONG);
    wire [7:0] rx_total = long_rsp ? `CCI_RSP_LONG_BITS :
                          `CCI_RSP_SHORT_BITS;
    wire [7:0] crc_lo = long_rsp ? `CCI_CRC_LO_LONG : `CCI_CRC_LO_SHORT;
    wire [7:0] crc_hi = long_rsp ? `CCI_CRC_HI_LONG : `CCI_CRC_HI_SHORT;
    wire [6:0] lat_lim = lat_sel ? `CCI_LAT_LONG_CYC :
                         `CCI_LAT_SHORT_CYC;
    wire [135:0] next_frame = {rx_shift[134:0], cmd_s};
    wire rx_last = (rx_cnt == rx_total - 8'h01);

    always @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            state <= S_IDLE;
            tx_shift <= 48'h0000_0000_0000;
            tx_cnt <= 8'h00;
            cmd_bit <= `CCI_IDLE_LEVEL;
            cmd_drive <= 1'b0;
            od_mode <= 1'b0;
            rsp_kind <= `CCI_RSP_NONE;
            cmd_index <= 6'h00;
            lat_sel <= 1'b0;
            wait_cnt <= 7'h00;
            rx_shift <= 136'h0;
            rx_cnt <= 8'h00;
            rx_crc <= `CCI_CRC7_INIT;
            xfer_cmd <= 2'h0;
            xfer_dir <= 1'b0;
            xfer_kind <= 3'h0;
        end else begin
            case (state)
                S_IDLE: begin
                    if (accept) begin
                        // Index 2 is sent broadcast like any other.
                        tx_shift <= {head, crc7_head(head),
                                     `CCI_CMD_END_BIT};
                        tx_cnt <= `CCI_CMD_FRAME_BITS;
                        od_mode <= OPEN_DRAIN_IN;
                        rsp_kind <= RSP_KIND_IN;
                        cmd_index <= CMD_INDEX_IN;
                        lat_sel <= LATENCY_IN;
                        xfer_cmd <= XFER_CMD_IN;
                        if (XFER_CMD_IN == 2'h0) begin
                            xfer_dir <= 1'b0;
                            xfer_kind <= 3'h0;
                        end else begin
                            xfer_dir <= XFER_DIR_IN;
                            xfer_kind <= XFER_KIND_IN;
                        end
                        state <= S_SEND;
                    end
                end
                S_SEND: begin
                    if (fall_tick) begin
                        if (tx_cnt != 8'h00) begin
                            cmd_bit <= tx_shift[47];
                            cmd_drive <= 1'b1;
                            tx_shift <= {tx_shift[46:0], 1'b0};
                            tx_cnt <= tx_cnt - 8'h01;
                        end else begin
                            cmd_bit <= `CCI_IDLE_LEVEL;
                            cmd_drive <= 1'b0;
                            wait_cnt <= 7'h00;
                            rx_shift <= 136'h0;
                            if (rsp_kind == `CCI_RSP_NONE) begin
                                state <= S_IDLE;
                            end else begin
                                state <= S_WAIT;
                            end
                        end
                    end
                end
                S_WAIT: begin
                    if (rise_tick) begin
                        if (cmd_s == `CCI_START_LEVEL) begin
                            rx_shift <= next_frame;
                            rx_cnt <= 8'h01;
                            rx_crc <= long_rsp ? `CCI_CRC7_INIT :
                                      crc7_step(`CCI_CRC7_INIT, cmd_s);
                            state <= S_RECV;
                        end else if (wait_cnt == lat_lim) begin
                            state <= S_IDLE;
                        end else begin
                            wait_cnt <= wait_cnt + 7'h01;
                        end
                    end
                end
                S_RECV: begin
                    if (rise_tick) begin
                        rx_shift <= next_frame;
                        rx_cnt <= rx_cnt + 8'h01;
                        if (rx_cnt >= crc_lo && rx_cnt <= crc_hi) begin
                            rx_crc <= crc7_step(rx_crc, cmd_s);
                        end
                        if (rx_last) begin
                            wait_cnt <= 7'h00;
                            if (rsp_kind == `CCI_RSP_BUSY) begin
                                state <= S_BUSY;
                            end else begin
                                state <= S_IDLE;
                            end
                        end
                    end
                end
                S_BUSY: begin
                    if (rise_tick) begin
                        if (wait_cnt != `CCI_BUSY_GUARD_CYC) begin
                            wait_cnt <= wait_cnt + 7'h01;
                        end else if (!card_busy) begin
                            state <= S_IDLE;
                        end
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Events
    // ----------------------------------------------------------------
    wire rx_done = state[3] & rise_tick & rx_last;

    always @* begin
        ev_timeout = state[2] & rise_tick & (cmd_s != `CCI_START_LEVEL) &
                     (wait_cnt == lat_lim);
        ev_crc = rx_done & (rx_crc != rx_shift[6:0]);
        ev_end = rx_done & (cmd_s != `CCI_CMD_END_BIT);
        ev_idx = rx_done & (rsp_kind == `CCI_RSP_SHORT ||
                 rsp_kind == `CCI_RSP_BUSY) &
                 (next_frame[`CCI_IDX_HI:`CCI_IDX_LO] != cmd_index);
        ev_released = state[4] & rise_tick &
                      (wait_cnt == `CCI_BUSY_GUARD_CYC) & ~card_busy;
        ev_refused = CMD_WR_IN & ~accept;
    end

    // ----------------------------------------------------------------
    // Status flags: bits 6..1 sticky, cleared by a status read, set wins; bit 0 is the live ready state
    // ----------------------------------------------------------------
    reg [`CCI_ST_WIDTH-1:0] sticky;
    wire [`CCI_ST_WIDTH-1:0] set_vec;
    wire [`CCI_ST_WIDTH-1:0] status;

    assign set_vec = {ev_refused, ev_idx, ev_end, ev_crc, ev_timeout,
                      ev_released, 1'b0};

    always @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            sticky <= {`CCI_ST_WIDTH{1'b0}};
        end else begin
            sticky <= (STATUS_RD_IN ? {`CCI_ST_WIDTH{1'b0}} : sticky) |
                      set_vec;
        end
    end

    assign status = {sticky[`CCI_ST_WIDTH-1:1], state[0]};

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign CARD_CLK_OUT = card_clk;
    assign CMD_OUT = od_mode ? 1'b0 : cmd_bit;
    assign CMD_OE_OUT = cmd_drive &
                        (~od_mode | (cmd_bit == 1'b0));
    assign ARG_OUT = arg_reg;
    assign RESP_OUT = rx_shift;
    assign XFER_CMD_OUT = xfer_cmd;
    assign XFER_DIR_OUT = xfer_dir;
    assign XFER_KIND_OUT = xfer_kind;
    assign STATUS_OUT = status;
    assign IRQ_OUT = |(status & INT_EN_IN);

endmodule

// *** cci_consts.vh ***
// Constants for the card command issue block.
`ifndef CCI_CONSTS_VH
`define CCI_CONSTS_VH

// ----------------------------------------------------------------
// Command frame
// ----------------------------------------------------------------
`define CCI_CMD_FRAME_BITS 8'h30
`define CCI_CMD_PREFIX 2'h1
`define CCI_CMD_END_BIT 1'h1
`define CCI_CRC7_POLY 7'h09
`define CCI_CRC7_INIT 7'h00
`define CCI_IDLE_LEVEL 1'h1
`define CCI_START_LEVEL 1'h0

// ----------------------------------------------------------------
// Response kinds and sizes
// ----------------------------------------------------------------
`define CCI_RSP_NONE 2'h0
`define CCI_RSP_SHORT 2'h1
`define CCI_RSP_LONG 2'h2
`define CCI_RSP_BUSY 2'h3
`define CCI_RSP_SHORT_BITS 8'h30
`define CCI_RSP_LONG_BITS 8'h88
`define CCI_CRC_LO_SHORT 8'h00
`define CCI_CRC_HI_SHORT 8'h27
`define CCI_CRC_LO_LONG 8'h08
`define CCI_CRC_HI_LONG 8'h7F
`define CCI_IDX_HI 45
`define CCI_IDX_LO 40

// ----------------------------------------------------------------
// Response latency and busy guard in card clock cycles
// ----------------------------------------------------------------
`define CCI_LAT_SHORT_CYC 7'h05
`define CCI_LAT_LONG_CYC 7'h40
`define CCI_BUSY_GUARD_CYC 7'h02

// ----------------------------------------------------------------
// Card clock: 80 ns period from the 10 ns system clock
// ----------------------------------------------------------------
`define CCI_SYS_PERIOD_NS 10
`define CCI_CARD_PERIOD_NS 80
`define CCI_CARD_HALF_CYC (`CCI_CARD_PERIOD_NS / (2 * `CCI_SYS_PERIOD_NS))

// ----------------------------------------------------------------
// Status bit positions
// ----------------------------------------------------------------
`define CCI_ST_WIDTH 7
`define CCI_ST_READY 0
`define CCI_ST_RELEASED 1
`define CCI_ST_TIMEOUT 2
`define CCI_ST_CRC_ERR 3
`define CCI_ST_END_ERR 4
`define CCI_ST_IDX_ERR 5
`define CCI_ST_REFUSED 6

`endif

// *** cci_checker_asserts.sv ***
// Port assertions for the card command issue block.
`timescale 1ns/100ps
module cci_checker #(
    parameter CLK_HALF = 4
) (
    input wire SYS_CLK_IN,
    input wire RST_N_IN,
    input wire CMD_WR_IN,
    input wire [2:0] SPECIAL_SEQ_IN,
    input wire OPEN_DRAIN_IN,
    input wire [1:0] IO_SPECIAL_SEQ_IN,
    input wire [6:0] INT_EN_IN,
    input wire CARD_CLK_OUT,
    input wire CMD_OUT,
    input wire CMD_OE_OUT,
    input wire [1:0] XFER_CMD_OUT,
    input wire XFER_DIR_OUT,
    input wire [2:0] XFER_KIND_OUT,
    input wire [6:0] STATUS_OUT,
    input wire IRQ_OUT
);
    reg [7:0] nbit;
    reg od;
    wire go = CMD_WR_IN && STATUS_OUT[0] && SPECIAL_SEQ_IN == 3'h0 &&
        IO_SPECIAL_SEQ_IN == 2'h0;
    default clocking @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    // Counts card clock falls while the block drives a frame.
    always @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            nbit <= 8'h00;
            od <= 1'b0;
        end else begin
            if (go)
                od <= OPEN_DRAIN_IN;
            if (!CMD_OE_OUT)
                nbit <= 8'h00;
            else if ($fell(CARD_CLK_OUT))
                nbit <= nbit + 8'h01;
        end
    end
    a_ready_drops: assert property (go |=> !STATUS_OUT[0])
        else $error("ready stayed high after an accepted command");
    a_start_soon: assert property (go |-> ##[1:10] $rose(CMD_OE_OUT))
        else $error("command did not start on the line");
    a_start_low: assert property ($rose(CMD_OE_OUT) |-> !CMD_OUT)
        else $error("frame did not open with a low bit");
    a_frame_len: assert property ($fell(CMD_OE_OUT) && !od |->
        nbit == 8'h30)
        else $error("command frame length wrong");
    a_refuse_flag: assert property (CMD_WR_IN &&
        (SPECIAL_SEQ_IN != 3'h0 || IO_SPECIAL_SEQ_IN != 2'h0) |=> STATUS_OUT[6])
        else $error("special command not refused");
    a_open_drain: assert property (od && CMD_OE_OUT |-> !CMD_OUT)
        else $error("line driven high in open-drain mode");
    a_oe_on_fall: assert property ($changed(CMD_OE_OUT) |->
        $fell(CARD_CLK_OUT))
        else $error("line drive changed off the card clock fall");
    a_irq_level: assert property (IRQ_OUT == |(STATUS_OUT & INT_EN_IN))
        else $error("interrupt output does not match enabled status");
    a_xfer_ignored: assert property (XFER_CMD_OUT == 2'h0 |->
        XFER_DIR_OUT == 1'b0 && XFER_KIND_OUT == 3'h0)
        else $error("transfer fields kept without a transfer");
endmodule
bind cci_card_command_issue cci_checker #(.CLK_HALF(CLK_HALF)) chk (
    .SYS_CLK_IN(SYS_CLK_IN), .RST_N_IN(RST_N_IN), .CMD_WR_IN(CMD_WR_IN),
    .SPECIAL_SEQ_IN(SPECIAL_SEQ_IN), .OPEN_DRAIN_IN(OPEN_DRAIN_IN),
    .IO_SPECIAL_SEQ_IN(IO_SPECIAL_SEQ_IN), .INT_EN_IN(INT_EN_IN),
    .CARD_CLK_OUT(CARD_CLK_OUT), .CMD_OUT(CMD_OUT), .CMD_OE_OUT(CMD_OE_OUT),
    .XFER_CMD_OUT(XFER_CMD_OUT), .XFER_DIR_OUT(XFER_DIR_OUT),
    .XFER_KIND_OUT(XFER_KIND_OUT), .STATUS_OUT(STATUS_OUT), .IRQ_OUT(IRQ_OUT));

// *** cci_card_model.sv ***
// Behavioural memory card answering on the command line.
`timescale 1ns/100ps
module cci_card_model (
    input wire clk_in,
    input wire cmd_in,
    input wire [1:0] kind_in,
    input wire [6:0] gap_in,
    input wire bad_in,
    input wire [7:0] busy_in,
    input wire [119:0] pay_in,
    output reg oe_out,
    output reg val_out,
    output reg dat0_out
);
    reg [47:0] rx;
    reg [135:0] tx;
    reg [5:0] nrx;
    reg [7:0] got, seen, wait_c, left, busy;
    function [6:0] crc7(input [119:0] d, input integer len);
        integer i;
        begin
            crc7 = 7'h00;
            for (i = len - 1; i >= 0; i = i - 1)
                crc7 = {crc7[5:0], 1'b0} ^ ((d[i] ^ crc7[6]) ? 7'h09 : 7'h00);
        end
    endfunction
    initial begin
        {rx, tx, nrx, got, seen, wait_c, left, busy, oe_out} = 231'h0;
        val_out = 1'b1;
        dat0_out = 1'b1;
    end
    // --------------------------------------------------------------
    // Commands are sampled on card clock rises, answers launched on falls.
    // --------------------------------------------------------------
    always @(posedge clk_in) begin
        if (nrx != 6'h00 || (!cmd_in && !oe_out && left == 8'h00)) begin
            rx = {rx[46:0], cmd_in};
            nrx = (nrx == 6'h2F) ? 6'h00 : nrx + 6'h01;
            if (nrx == 6'h00)
                got = got + 8'h01;
        end
    end
    always @(negedge clk_in) begin
        if (got != seen) begin
            seen = got;
            wait_c = (kind_in == 2'h0) ? 8'h00 : {1'b0, gap_in};
        end else if (wait_c != 8'h00) begin
            wait_c = wait_c - 8'h01;
            if (wait_c == 8'h00) begin
                left = (kind_in == 2'h2) ? 8'h88 : 8'h30;
                tx = (kind_in == 2'h2) ? {8'h3F, pay_in,
                    crc7(pay_in, 120) ^ {6'h00, bad_in}, 1'b1} :
                    {2'b00, rx[45:40], pay_in[31:0], crc7({80'h0, 2'b00,
                    rx[45:40], pay_in[31:0]}, 40) ^ {6'h00, bad_in}, 1'b1, 88'h0};
            end
        end
        if (left != 8'h00) begin
            oe_out = 1'b1;
            val_out = tx[135];
            tx = tx << 1;
            left = left - 8'h01;
        end else if (oe_out) begin
            oe_out = 1'b0;
            val_out = ~val_out;
            if (kind_in == 2'h3)
                busy = busy_in;
        end
        dat0_out = (busy == 8'h00);
        if (busy != 8'h00)
            busy = busy - 8'h01;
    end
endmodule

// *** cci_testbench.sv ***
// Self-checking bench for the card command issue block.
`timescale 1ns/100ps
module testbench;
    reg SYS_CLK_IN, RST_N_IN, ARG_WR_IN, CMD_WR_IN, OPEN_DRAIN_IN, LATENCY_IN;
    reg XFER_DIR_IN, STATUS_RD_IN, bad;
    reg [31:0] ARG_IN;
    reg [5:0] CMD_INDEX_IN;
    reg [1:0] RSP_KIND_IN, XFER_CMD_IN, IO_SPECIAL_SEQ_IN, mk, rk;
    reg [2:0] SPECIAL_SEQ_IN, XFER_KIND_IN;
    reg [6:0] INT_EN_IN, gap;
    reg [7:0] busy;
    reg [127:0] pay;
    wire CARD_CLK_OUT, CMD_OUT, CMD_OE_OUT, XFER_DIR_OUT, IRQ_OUT;
    wire card_oe, card_val, dat0;
    wire [31:0] ARG_OUT;
    wire [135:0] RESP_OUT;
    wire [1:0] XFER_CMD_OUT;
    wire [2:0] XFER_KIND_OUT;
    wire [6:0] STATUS_OUT;
    // The command line has a pull-up, so it reads high when nobody drives.
    wire cmd_line = CMD_OE_OUT ? CMD_OUT : (card_oe ? card_val : 1'b1);
    integer seed, n_errors, check_count, i;
    cci_card_command_issue dut (.SYS_CLK_IN(SYS_CLK_IN), .RST_N_IN(RST_N_IN),
        .ARG_IN(ARG_IN), .ARG_WR_IN(ARG_WR_IN), .CMD_WR_IN(CMD_WR_IN),
        .CMD_INDEX_IN(CMD_INDEX_IN), .RSP_KIND_IN(RSP_KIND_IN),
        .SPECIAL_SEQ_IN(SPECIAL_SEQ_IN), .OPEN_DRAIN_IN(OPEN_DRAIN_IN),
        .LATENCY_IN(LATENCY_IN), .XFER_CMD_IN(XFER_CMD_IN),
        .XFER_DIR_IN(XFER_DIR_IN), .XFER_KIND_IN(XFER_KIND_IN),
        .IO_SPECIAL_SEQ_IN(IO_SPECIAL_SEQ_IN), .STATUS_RD_IN(STATUS_RD_IN),
        .INT_EN_IN(INT_EN_IN), .CMD_IN(cmd_line), .DAT0_IN(dat0),
        .CARD_CLK_OUT(CARD_CLK_OUT), .CMD_OUT(CMD_OUT), .CMD_OE_OUT(CMD_OE_OUT),
        .ARG_OUT(ARG_OUT), .RESP_OUT(RESP_OUT), .XFER_CMD_OUT(XFER_CMD_OUT),
        .XFER_DIR_OUT(XFER_DIR_OUT), .XFER_KIND_OUT(XFER_KIND_OUT),
        .STATUS_OUT(STATUS_OUT), .IRQ_OUT(IRQ_OUT));
    cci_card_model card (.clk_in(CARD_CLK_OUT), .cmd_in(cmd_line),
        .kind_in(mk), .gap_in(gap), .bad_in(bad), .busy_in(busy),
        .pay_in(pay[119:0]), .oe_out(card_oe), .val_out(card_val),
        .dat0_out(dat0));
    task check(input [135:0] seen, input [135:0] want);
        begin
            check_count = check_count + 1;
            if (seen !== want) begin
                n_errors = n_errors + 1;
                $display("unexpected at %0t: seen %h expected %h", $time, seen,
                    want);
            end
        end
    endtask
    task print_verdict;
        begin
            if (n_errors == 0 && check_count > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    task setm(input [1:0] k, input [6:0] g, input b, input [7:0] bz);
        begin
            {mk, gap, bad, busy} = {k, g, b, bz};
            pay = {$random(seed), $random(seed), $random(seed), $random(seed)};
        end
    endtask
    function [135:0] resp(input [5:0] idx, input [1:0] k);
        reg [39:0] h;
        begin
            h = {2'b00, idx, pay[31:0]};
            if (k == 2'h2)
                resp = {8'h3F, pay[119:0], card.crc7(pay[119:0], 120) ^
                    {6'h00, bad}, 1'b1};
            else
                resp = {88'h0, h, card.crc7({80'h0, h}, 40) ^ {6'h00, bad}, 1'b1};
        end
    endfunction
    // --------------------------------------------------------------
    // One command: argument first, then the command register.
    // --------------------------------------------------------------
    task issue(input [5:0] idx, input [1:0] k, input od, input lat,
        input [4:0] sp);
        reg [31:0] arg;
        reg [6:0] st;
        integer t;
        begin
            arg = $random(seed);
            @(negedge SYS_CLK_IN);
            {STATUS_RD_IN, ARG_WR_IN, ARG_IN} = {2'h3, arg};
            @(negedge SYS_CLK_IN);
            {STATUS_RD_IN, ARG_WR_IN, CMD_WR_IN} = 3'h1;
            {CMD_INDEX_IN, RSP_KIND_IN, OPEN_DRAIN_IN} = {idx, k, od};
            {LATENCY_IN, IO_SPECIAL_SEQ_IN, SPECIAL_SEQ_IN} = {lat, sp};
            {XFER_CMD_IN, XFER_DIR_IN, XFER_KIND_IN} = $random(seed);
            INT_EN_IN = $random(seed);
            @(negedge SYS_CLK_IN);
            CMD_WR_IN = 1'b0;
            check(ARG_OUT, arg);
            if (sp != 5'h00) begin
                check(STATUS_OUT, 7'h41);
            end else begin
                check(STATUS_OUT[0], 1'b0);
                t = 0;
                while (STATUS_OUT[0] !== 1'b1 && t < 30000) begin
                    @(negedge SYS_CLK_IN);
                    t = t + 1;
                end
                if (t == 30000) begin
                    n_errors = n_errors + 1;
                    print_verdict;
                end
                check(card.rx, {2'b01, idx, arg, card.crc7({80'h0, 2'b01, idx,
                    arg}, 40), 1'b1});
                check({XFER_CMD_OUT, XFER_DIR_OUT, XFER_KIND_OUT}, XFER_CMD_IN ==
                    2'h0 ? 6'h00 : {XFER_CMD_IN, XFER_DIR_IN, XFER_KIND_IN});
                st = {3'h0, bad && mk != 2'h0, k != 2'h0 && mk == 2'h0,
                    k == 2'h3, 1'b1};
                check(STATUS_OUT, st);
                check(IRQ_OUT, |(st & INT_EN_IN));
                if (k != 2'h0 && mk != 2'h0)
                    check(RESP_OUT, resp(idx, k));
            end
        end
    endtask
    initial begin
        SYS_CLK_IN = 1'b0;
        forever #5 SYS_CLK_IN = ~SYS_CLK_IN;
    end
    initial begin
        {seed, n_errors, check_count} = {32'd47859, 64'h0};
        {RST_N_IN, ARG_WR_IN, CMD_WR_IN, OPEN_DRAIN_IN, LATENCY_IN} = 5'h00;
        {XFER_DIR_IN, STATUS_RD_IN, ARG_IN, CMD_INDEX_IN, RSP_KIND_IN} = 42'h0;
        {XFER_CMD_IN, IO_SPECIAL_SEQ_IN, SPECIAL_SEQ_IN, XFER_KIND_IN} = 10'h0;
        INT_EN_IN = 7'h7F;
        setm(2'h0, 7'h02, 1'b0, 8'h00);
        repeat (20) @(negedge SYS_CLK_IN);
        RST_N_IN = 1'b1;
        repeat (3) @(negedge SYS_CLK_IN);
        check({STATUS_OUT, IRQ_OUT}, {7'h01, 1'b1});
        check(RESP_OUT, 136'h0);
        check(ARG_OUT, 32'h0);
        setm(2'h2, 7'h02, 1'b0, 8'h00);
        issue(6'h02, 2'h2, 1'b1, 1'b0, 5'h00);
        setm(2'h1, 7'h02, 1'b0, 8'h00);
        issue(6'h11, 2'h1, 1'b0, 1'b0, 5'h00);
        setm(2'h0, 7'h02, 1'b0, 8'h00);
        issue(6'h00, 2'h0, 1'b0, 1'b0, 5'h00);
        setm(2'h3, 7'h02, 1'b0, 8'h1E);
        issue(6'h0C, 2'h3, 1'b0, 1'b0, 5'h00);
        setm(2'h1, 7'h02, 1'b1, 8'h00);
        issue(6'h0D, 2'h1, 1'b0, 1'b0, 5'h00);
        setm(2'h0, 7'h02, 1'b0, 8'h00);
        issue(6'h0D, 2'h1, 1'b0, 1'b0, 5'h00);
        setm(2'h1, 7'h14, 1'b0, 8'h00);
        issue(6'h0D, 2'h1, 1'b0, 1'b1, 5'h00);
        issue(6'h05, 2'h1, 1'b0, 1'b0, 5'h01);
        issue(6'h05, 2'h1, 1'b0, 1'b0, 5'h08);
        for (i = 0; i < 5; i = i + 1) begin
            rk = ($random(seed) & 1) ? 2'h2 : 2'h1;
            setm(rk, 7'h02 + ($random(seed) & 7'h03), 1'b0, 8'h00);
            issue($random(seed), rk, $random(seed), 1'b0, 5'h00);
        end
        print_verdict;
    end
endmodule
